/* core/sac_pkg.sv */
// Constants shared by the converter pin-control block and its helpers.
// Assumes one 125 MHz clock and a synchronous active-low reset.
package sac_pkg;

  // Bus and stream geometry
  localparam int DATA_W     = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int PAIR_N     = 3;

  // Data line positions with a special role
  localparam int POS_SERIAL_C   = 10;
  localparam int POS_REFBUF     = 14;
  localparam int POS_BYTE_ORDER = 7;
  localparam int BYTE_HI_LSB    = 8;

  // Control register layout: pair selects and pair ranges
  localparam int CTRL_SEL_LSB = 13;
  localparam int CTRL_RNG_LSB = 10;

  // Reset values
  localparam logic [DATA_W-1:0] CTRL_RST   = 16'h0000;
  localparam logic [DATA_W-1:0] DOUT_RST   = 16'h0000;
  localparam logic [PAIR_N-1:0] RANGE_RST  = 3'h0;

  // Resolution variants
  localparam int RES_FULL = 16;
  localparam int RES_MID  = 14;
  localparam int RES_LOW  = 12;

  // Host reset pulse, used by the host model to time the device reset
  localparam int CLK_PERIOD_NS   = 8;
  localparam int RESET_PULSE_NS  = 100;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Byte-read phase
  typedef enum logic [1:0] {
    SAC_RD_IDLE   = 2'b00,
    SAC_RD_FIRST  = 2'b01,
    SAC_RD_GAP    = 2'b10,
    SAC_RD_SECOND = 2'b11
  } sac_rd_state_type;

endpackage

/* core/sac_fifo.sv */
// Result buffer between converter core and parallel read port.
// Assumes single clock; flush has priority over push and pop.
`timescale 1ns/100ps
module sac_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];

  // Storage has no reset; only pointers and fill level carry state
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_sys) begin
    if (!rstn || flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      case ({push, pop})
        2'b10:   count_reg <= count_reg + 1'b1;
        2'b01:   count_reg <= count_reg - 1'b1;
        default: count_reg <= count_reg;
      endcase
    end
  end
endmodule

/* core/sac_start_arm.sv */
// Conversion-start edge detector for one converter pair.
// Assumes the start pin is synchronous to clk_sys.
`timescale 1ns/100ps
module sac_start_arm (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic chip_reset,
  input  wire logic start_pin,
  output logic      start_pulse
);
  logic prev_reg;
  logic block_reg;

  // A pin held low through chip reset must rise and fall once before a rise starts a conversion
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      prev_reg  <= 1'b1;
      block_reg <= 1'b0;
    end else if (chip_reset) begin
      prev_reg  <= start_pin;
      block_reg <= !start_pin;
    end else begin
      prev_reg <= start_pin;
      if (prev_reg && !start_pin) begin
        block_reg <= 1'b0;
      end
    end
  end

  assign start_pulse = !chip_reset && !block_reg && !prev_reg && start_pin;
endmodule

/* core/sac_pin_ctrl.sv */
// Host pin control of a six-channel simultaneous-sampling converter.
// Assumes every pin input is synchronous to clk_sys and that the
// analog core reports busy and hands over results on a valid/ready stream.
`timescale 1ns/100ps
module sac_pin_ctrl
  import sac_pkg::*;
#(
  parameter int RESOLUTION = RES_FULL
) (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic              chip_reset,
  input  wire logic              serial_parallel_select,
  input  wire logic              hw_sw_select,
  input  wire logic              word_byte,
  input  wire logic              standby_n,
  input  wire logic              range_pin,
  input  wire logic              conversion_start_pair_a,
  input  wire logic              conversion_start_pair_b,
  input  wire logic              conversion_start_pair_c,
  input  wire logic              cs_n,
  input  wire logic              rd_n,
  input  wire logic              wr_n,
  input  wire logic [DATA_W-1:0] db_in,
  output logic      [DATA_W-1:0] db_out,
  output logic      [DATA_W-1:0] db_oe,
  input  wire logic              serial_select_c,
  input  wire logic              serial_data_c,
  input  wire logic              core_busy,
  input  wire logic              result_valid,
  input  wire logic [DATA_W-1:0] result_data,
  output logic                   result_ready,
  output logic                   busy,
  output logic      [PAIR_N-1:0] pair_start,
  output logic      [PAIR_N-1:0] pair_range,
  output logic                   conversion_abort,
  output logic                   converters_standby_n,
  output logic                   reference_buffer_control,
  output logic      [DATA_W-1:0] control_value
);

  // Leading zero mask for reduced-resolution parts
  localparam logic [DATA_W-1:0] RES_MASK = 16'hFFFF >> (DATA_W - RESOLUTION);

  logic [DATA_W-1:0]  ctrl_reg;
  logic [DATA_W-1:0]  wr_hold_reg;
  logic               wr_act_prev_reg;
  logic               rd_act_prev_reg;
  logic               busy_prev_reg;
  logic               range_hw_reg;
  logic [PAIR_N-1:0]  start_reg;
  logic               abort_reg;
  logic               standby_n_reg;
  logic               refbuf_reg;
  logic               ready_reg;
  logic [DATA_W-1:0]  dout_reg;
  logic [DATA_W-1:0]  doe_reg;
  logic [DATA_W-1:0]  first_byte_word_reg;
  sac_rd_state_type   rd_state_reg;
  sac_rd_state_type   rd_state_next;

  logic               par_mode;
  logic               sw_mode;
  logic               byte_mode;
  logic               rd_act;
  logic               wr_act;
  logic               rd_begin;
  logic               rd_end;
  logic [PAIR_N-1:0]  pin_vec;
  logic [PAIR_N-1:0]  edge_vec;
  logic [PAIR_N-1:0]  start_next;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic               fifo_pop;
  logic [DATA_W-1:0]  fifo_data;
  logic [DATA_W-1:0]  head_word;

  // Mode decode; word/byte is ignored in serial mode, where the host grounds it
  assign par_mode  = !serial_parallel_select;
  assign sw_mode   = hw_sw_select;
  assign byte_mode = par_mode && word_byte;
  assign rd_act    = par_mode && !cs_n && !rd_n;
  assign wr_act    = par_mode && !cs_n && !wr_n;
  assign rd_begin  = rd_act && !rd_act_prev_reg;
  assign rd_end    = !rd_act && rd_act_prev_reg;

  // Head of the buffer with top bits forced low; zero when nothing is buffered
  assign head_word = fifo_out_valid ? (fifo_data & RES_MASK) : DOUT_RST;

  assign pin_vec = {conversion_start_pair_c, conversion_start_pair_b,
                    conversion_start_pair_a};

  // Per-pair start edge detectors
  genvar gi;
  generate
    for (gi = 0; gi < PAIR_N; gi++) begin : g_pair
      sac_start_arm u_arm (
        .clk_sys     (clk_sys),
        .rstn        (rstn),
        .chip_reset  (chip_reset),
        .start_pin   (pin_vec[gi]),
        .start_pulse (edge_vec[gi])
      );
    end
  endgenerate

  // Pair selection: pins in hardware mode, register plus pair A pin in software mode
  always_comb begin
    start_next = '0;
    if (!standby_n) begin
      start_next = '0;
    end else if (sw_mode) begin
      start_next = edge_vec[0] ? ctrl_reg[CTRL_SEL_LSB +: PAIR_N] : '0;
    end else begin
      start_next = edge_vec;
    end
  end

  // Start pulses to the analog core, one cycle each
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      start_reg <= '0;
    end else begin
      start_reg <= start_next;
    end
  end

  // Abort while chip reset is held in software mode
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      abort_reg <= 1'b0;
    end else begin
      abort_reg <= chip_reset && sw_mode;
    end
  end

  // Standby follows the pin; it only parks the core, the host port stays alive
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      standby_n_reg <= 1'b1;
    end else begin
      standby_n_reg <= standby_n;
    end
  end

  // Serial mode lends line fourteen to the reference buffer enable
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      refbuf_reg <= 1'b1;
    end else if (!par_mode) begin
      refbuf_reg <= db_in[POS_REFBUF];
    end else begin
      refbuf_reg <= 1'b1;
    end
  end

  // Write strobe: sample data while held, commit on release
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wr_act_prev_reg <= 1'b0;
      wr_hold_reg     <= CTRL_RST;
    end else begin
      wr_act_prev_reg <= wr_act;
      if (wr_act) begin
        wr_hold_reg <= db_in;
      end
    end
  end

  // Control register; chip reset wins over a write ending in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl_reg <= CTRL_RST;
    end else if (chip_reset && sw_mode) begin
      ctrl_reg <= CTRL_RST;
    end else if (!wr_act && wr_act_prev_reg && !chip_reset) begin
      ctrl_reg <= wr_hold_reg;
    end
  end

  // Busy mirror and its previous level for fall detection
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      busy_prev_reg <= 1'b0;
    end else begin
      busy_prev_reg <= core_busy;
    end
  end

  // Hardware range: taken from the pin at reset and at each busy fall
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      range_hw_reg <= 1'b0;
    end else if (chip_reset && !sw_mode) begin
      range_hw_reg <= range_pin;
    end else if (busy_prev_reg && !core_busy) begin
      range_hw_reg <= range_pin;
    end
  end

  // Range per pair: one means the narrower two-times span
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pair_range <= RANGE_RST;
    end else if (sw_mode) begin
      pair_range <= ctrl_reg[CTRL_RNG_LSB +: PAIR_N];
    end else begin
      pair_range <= {PAIR_N{range_hw_reg}};
    end
  end

  // Byte-read sequencing: first read shows one byte, second shows the other
  always_comb begin
    rd_state_next = rd_state_reg;
    case (rd_state_reg)
      SAC_RD_IDLE: begin
        if (rd_begin && byte_mode) begin
          rd_state_next = SAC_RD_FIRST;
        end
      end
      SAC_RD_FIRST: begin
        if (rd_end) begin
          rd_state_next = SAC_RD_GAP;
        end
      end
      SAC_RD_GAP: begin
        if (rd_begin) begin
          rd_state_next = SAC_RD_SECOND;
        end else if (!byte_mode) begin
          rd_state_next = SAC_RD_IDLE;
        end
      end
      SAC_RD_SECOND: begin
        if (rd_end) begin
          rd_state_next = SAC_RD_IDLE;
        end
      end
      default: rd_state_next = SAC_RD_IDLE;
    endcase
  end

  // Read state and strobe history; chip reset drops a half-read word
  always_ff @(posedge clk_sys) begin
    if (!rstn || chip_reset) begin
      rd_state_reg    <= SAC_RD_IDLE;
      rd_act_prev_reg <= 1'b0;
    end else begin
      rd_state_reg    <= rd_state_next;
      rd_act_prev_reg <= rd_act;
    end
  end

  // Word leaves the buffer once fully read: word read end or second byte end
  assign fifo_pop = rd_end && ((rd_state_reg == SAC_RD_SECOND) ||
                               (rd_state_reg == SAC_RD_IDLE));

  // Word latched at the first byte so both bytes come from one result
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      first_byte_word_reg <= DOUT_RST;
    end else if (rd_begin && rd_state_reg == SAC_RD_IDLE) begin
      first_byte_word_reg <= head_word;
    end
  end

  // Data line drive and enables
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dout_reg <= DOUT_RST;
      doe_reg  <= '0;
    end else if (!par_mode) begin
      dout_reg               <= DOUT_RST;
      doe_reg                <= '0;
      dout_reg[POS_SERIAL_C] <= serial_data_c;
      doe_reg[POS_SERIAL_C]  <= serial_select_c;
    end else if (rd_act && !byte_mode) begin
      dout_reg <= rd_begin ? head_word : dout_reg;
      doe_reg  <= 16'hFFFF;
    end else if (rd_act) begin
      // Upper lines only; line seven stays an input for byte order
      doe_reg <= 16'hFF00;
      if (rd_begin) begin
        if ((rd_state_reg == SAC_RD_IDLE) == db_in[POS_BYTE_ORDER]) begin
          dout_reg <= {(rd_state_reg == SAC_RD_IDLE ? head_word[15:8]
                        : first_byte_word_reg[15:8]), 8'h00};
        end else begin
          dout_reg <= {(rd_state_reg == SAC_RD_IDLE ? head_word[7:0]
                        : first_byte_word_reg[7:0]), 8'h00};
        end
      end
    end else begin
      doe_reg <= '0;
    end
  end

  // Back-pressure to the core is registered; no room is kept spare, so a word offered the cycle after the buffer fills is dropped
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= fifo_in_ready;
    end
  end

  // Result buffer; flushed by chip reset so stale results are not read
  sac_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .flush     (chip_reset),
    .in_valid  (result_valid && ready_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (result_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // Busy shown to the host
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      busy <= 1'b0;
    end else begin
      busy <= core_busy;
    end
  end

  // Output mirrors
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      control_value <= CTRL_RST;
    end else begin
      control_value <= ctrl_reg;
    end
  end

  assign db_out                   = dout_reg;
  assign db_oe                    = doe_reg;
  assign result_ready             = ready_reg;
  assign pair_start               = start_reg;
  assign conversion_abort         = abort_reg;
  assign converters_standby_n     = standby_n_reg;
  assign reference_buffer_control = refbuf_reg;

endmodule

/* dv/sac_pin_ctrl_monitor.sv */
// Checker for the converter pin-control block; sees its ports only.
// Assumes one clock and rstn synchronous, active low.
`timescale 1ns/100ps
module sac_pin_ctrl_monitor
  import sac_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        chip_reset,
  input wire logic        serial_parallel_select,
  input wire logic        hw_sw_select,
  input wire logic        word_byte,
  input wire logic        standby_n,
  input wire logic        range_pin,
  input wire logic        conversion_start_pair_a,
  input wire logic        conversion_start_pair_b,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic [15:0] db_in,
  input wire logic [15:0] db_oe,
  input wire logic        core_busy,
  input wire logic [2:0]  pair_start,
  input wire logic [2:0]  pair_range,
  input wire logic        conversion_abort,
  input wire logic        converters_standby_n,
  input wire logic [15:0] control_value,
  input wire logic        reference_buffer_control
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Parallel read strobes held over two sampled cycles
  sequence s_read(logic bw);
    !serial_parallel_select && word_byte == bw && !cs_n && !rd_n ##1 !cs_n && !rd_n;
  endsequence

  // Busy fall in hardware mode with no device reset around it
  sequence s_busy_fall;
    !hw_sw_select && !chip_reset && $fell(core_busy) ##1 !chip_reset;
  endsequence

  a_abort_sw_reset: assert property (
    chip_reset && hw_sw_select |=> conversion_abort) else $error("abort missing");
  a_ctrl_sw_clear: assert property (
    chip_reset && hw_sw_select |-> ##2 control_value == 16'h0000) else $error("ctrl kept");
  a_refbuf_follows: assert property (
    serial_parallel_select |=> reference_buffer_control == $past(db_in[POS_REFBUF]))
    else $error("refbuf wrong");
  a_range_busy_fall: assert property (
    s_busy_fall |=> pair_range == {3{$past(range_pin, 2)}}) else $error("range latch wrong");
  a_range_from_ctrl: assert property (
    (hw_sw_select && $stable(control_value)) [*3] |-> pair_range == control_value[12:10])
    else $error("sw range wrong");
  a_standby_blocks: assert property (
    !standby_n [*2] |-> pair_start == 3'h0 && !converters_standby_n) else $error("standby");
  a_hw_pair_b: assert property (
    !$past(hw_sw_select) && pair_start[1] |->
      $past(conversion_start_pair_b) && !$past(conversion_start_pair_b, 2))
    else $error("pair b start wrong");
  a_sw_pair_a: assert property (
    $past(hw_sw_select) && pair_start != 3'h0 |-> pair_start == control_value[15:13] &&
      $past(conversion_start_pair_a) && !$past(conversion_start_pair_a, 2))
    else $error("sw start wrong");
  a_word_read_oe: assert property (
    s_read(1'b0) |-> db_oe == 16'hFFFF) else $error("word read not driven");
  a_byte_read_oe: assert property (
    s_read(1'b1) |-> db_oe == 16'hFF00) else $error("byte read lanes wrong");
  a_serial_lines: assert property (
    serial_parallel_select [*2] |-> (db_oe & 16'hFBFF) == 16'h0000) else $error("serial oe");
endmodule

bind sac_pin_ctrl sac_pin_ctrl_monitor u_monitor (.*);

/* dv/sac_host_model.sv */
// Host model: drives strobes, data lines and the device reset pin.
// Assumes every task is entered just after a rising edge of clk_sys.
`timescale 1ns/100ps
module sac_host_model
  import sac_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        serial_parallel_select,
  input  wire logic [15:0] db_out,
  input  wire logic [15:0] db_oe,
  output logic             chip_reset,
  output logic             cs_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic             word_byte,
  output logic      [15:0] db_in
);
  logic [15:0] hdrv;
  logic [15:0] hoe;
  logic [15:0] last;
  logic        byte_mode;
  logic        refbuf;

  initial begin
    chip_reset = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    hdrv = 16'h0000;
    hoe = 16'h0000;
    last = 16'h0000;
    byte_mode = 1'b0;
    refbuf = 1'b1;
  end

  // Word/byte held low in serial mode
  assign word_byte = serial_parallel_select ? 1'b0 : byte_mode;

  // Wire level; an undriven line shows the inverse of its last level
  always_comb begin
    db_in = (hoe & hdrv) | (~hoe & db_oe & db_out) | (~hoe & ~db_oe & ~last);
    if (serial_parallel_select) begin
      db_in[15:11] = {1'b0, refbuf, 3'h0};
    end
  end

  always @(posedge clk_sys) begin
    last <= db_in;
  end

  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask

  // Reset pulse of about 100 ns, also usable between conversions
  task automatic reset_pulse;
    chip_reset = 1'b1;
    repeat (RESET_PULSE_CYC) tick;
    chip_reset = 1'b0;
    tick;
  endtask

  // Control write: strobes low one cycle, then one idle cycle
  task automatic write_ctrl(input logic [15:0] d);
    hdrv = d;
    hoe = 16'hFFFF;
    cs_n = 1'b0;
    wr_n = 1'b0;
    tick;
    cs_n = 1'b1;
    wr_n = 1'b1;
    hoe = 16'h0000;
    tick;
  endtask

  // Read; in byte mode line 7 carries the byte order
  task automatic read_bus(input logic bm, input logic hi_first, output logic [15:0] q);
    byte_mode = bm;
    tick;
    hdrv = {8'h00, hi_first, 7'h00};
    hoe = bm ? 16'h0080 : 16'h0000;
    cs_n = 1'b0;
    rd_n = 1'b0;
    tick;
    tick;
    q = db_in;
    cs_n = 1'b1;
    rd_n = 1'b1;
    hoe = 16'h0000;
    tick;
    tick;
  endtask
endmodule

/* dv/sac_pin_ctrl_tb.sv */
// Self-checking bench for the converter pin-control block.
// Assumes the host model owns strobes, data lines and the device reset.
`timescale 1ns/100ps
module sac_pin_ctrl_tb
  import sac_pkg::*;
;
  logic        clk_sys, rstn, chip_reset, serial_parallel_select, hw_sw_select;
  logic        word_byte, standby_n, range_pin, cs_n, rd_n, wr_n, core_busy;
  logic        conversion_start_pair_a, conversion_start_pair_b, conversion_start_pair_c;
  logic        serial_select_c, serial_data_c, result_valid, result_ready, busy;
  logic        conversion_abort, converters_standby_n, reference_buffer_control;
  logic [15:0] db_in, db_out, db_oe, result_data, control_value, q;
  logic [2:0]  pair_start, pair_range, pins;
  int          err_total, checks_done;

  assign {conversion_start_pair_c, conversion_start_pair_b, conversion_start_pair_a} = pins;

  sac_pin_ctrl   u_dut (.*);
  sac_host_model u_host (.*);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic summarize;
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Pin rise, then the one-cycle pulse and its end
  task automatic start_check(input int p, input logic [2:0] exp);
    pins[p] = 1'b1;
    tick;
    chk("pair_start", 16'(exp), 16'(pair_start));
    tick;
    chk("pair_start end", 16'h0000, 16'(pair_start));
    pins[p] = 1'b0;
    tick;
  endtask

  // Core side pushes words; the wait for ready is bounded
  task automatic fill(input int n, input logic [15:0] base);
    int w;
    for (int i = 0; i < n; i++) begin
      result_data = base + 16'(i);
      result_valid = 1'b1;
      w = 0;
      while (result_ready !== 1'b1 && w < 40) begin
        tick;
        w++;
      end
      if (w == 40) begin
        chk("result_ready", 16'h0001, 16'h0000);
        summarize;
      end
      tick;
    end
    result_valid = 1'b0;
  endtask

  task automatic t_write_sw;
    hw_sw_select = 1'b1;
    tick;
    u_host.write_ctrl(16'hA400);
    tick;
    tick;
    chk("control_value", 16'hA400, control_value);
    tick;
    tick;
    chk("pair_range sw", 16'h0001, 16'(pair_range));
    $display("test write done");
  endtask

  task automatic t_serial_sw;
    serial_parallel_select = 1'b1;
    tick;
    start_check(0, 3'h0);
    start_check(0, 3'b101);
    for (int j = 0; j < 2; j++) start_check(1, 3'h0);
    for (int b = 0; b < 2; b++) begin
      u_host.refbuf = b[0];
      tick;
      tick;
      chk("refbuf", 16'(b[0]), 16'(reference_buffer_control));
    end
    serial_select_c = 1'b1;
    serial_data_c = 1'b1;
    tick;
    tick;
    chk("serial oe", 16'h0400, db_oe);
    chk("serial bit", 16'h0400, db_out & 16'h0400);
    serial_select_c = 1'b0;
    // Abort is looked at while the device reset is still high
    fork
      u_host.reset_pulse;
      begin
        repeat (2) tick;
        chk("abort in reset", 16'h0001, 16'(conversion_abort));
      end
    join
    chk("abort after reset", 16'h0000, 16'(conversion_abort));
    chk("control cleared", 16'h0000, control_value);
    serial_parallel_select = 1'b0;
    tick;
    $display("test serial done");
  endtask

  task automatic t_hw_start;
    hw_sw_select = 1'b0;
    tick;
    for (int i = 0; i < 3; i++) begin
      start_check(i, 3'h0);
      start_check(i, 3'b001 << i);
    end
    standby_n = 1'b0;
    tick;
    tick;
    chk("standby out", 16'h0000, 16'(converters_standby_n));
    start_check(0, 3'h0);
    standby_n = 1'b1;
    tick;
    $display("test hw start done");
  endtask

  task automatic t_range_hw;
    range_pin = 1'b1;
    u_host.reset_pulse;
    tick;
    chk("range on reset", 16'h0007, 16'(pair_range));
    for (int r = 0; r < 2; r++) begin
      range_pin = r[0];
      core_busy = 1'b1;
      tick;
      chk("busy high", 16'h0001, 16'(busy));
      core_busy = 1'b0;
      tick;
      chk("busy low", 16'h0000, 16'(busy));
      range_pin = ~r[0];
      repeat (3) tick;
      chk("range at busy fall", 16'({3{r[0]}}), 16'(pair_range));
    end
    $display("test range done");
  endtask

  task automatic t_buffer;
    fill(FIFO_DEPTH, 16'h1230);
    tick;
    result_data = 16'hDEAD;
    result_valid = 1'b1;
    repeat (3) tick;
    chk("full refuses", 16'h0000, 16'(result_ready));
    result_valid = 1'b0;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      u_host.read_bus(1'b0, 1'b0, q);
      chk("word read", 16'h1230 + 16'(i), q);
    end
    fill(4, 16'hA5C3);
    for (int k = 0; k < 2; k++) begin
      u_host.read_bus(1'b1, ~k[0], q);
      chk("first byte", k[0] ? 16'h00C4 : 16'h00A5, 16'(q[15:8]));
      u_host.read_bus(1'b1, ~k[0], q);
      chk("second byte", k[0] ? 16'h00A5 : 16'h00C3, 16'(q[15:8]));
    end
    $display("test buffer done");
  endtask

  initial begin
    rstn = 1'b0;
    serial_parallel_select = 1'b0;
    hw_sw_select = 1'b0;
    standby_n = 1'b1;
    range_pin = 1'b0;
    pins = 3'h0;
    serial_select_c = 1'b0;
    serial_data_c = 1'b0;
    core_busy = 1'b0;
    result_valid = 1'b0;
    result_data = 16'h0000;
    err_total = 0;
    checks_done = 0;
    repeat (8) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    chk("standby out", 16'h0001, 16'(converters_standby_n));
    chk("refbuf reset", 16'h0001, 16'(reference_buffer_control));
    chk("oe reset", 16'h0000, db_oe);
    u_host.reset_pulse;
    t_write_sw;
    t_serial_sw;
    t_hw_start;
    t_range_hw;
    t_buffer;
    summarize;
  end
endmodule
